// ---- status_reporter_defs.vh ----
`ifndef STATUS_REPORTER_DEFS_VH
`define STATUS_REPORTER_DEFS_VH

`define REG_W            16
`define REG_ZERO         16'h0000
`define USED_BITS_MASK   16'h1fff
`define RISE_MASK        16'h1bff
`define FALL_MASK        16'h0f01
`define BIT_VALID        12
`define BIT_REMOTE       11
`define BIT_SWEEP        10
`define BIT_CAL_COMPENSATION_SWITCH      9
`define BIT_EXTERNAL_REFERENCE_SELECTED       8
`define BIT_AM_OVER      7
`define BIT_AM_UNDER     6
`define BIT_FM_OVER      5
`define BIT_FM_UNDER     4
`define BIT_REV_POWER    3
`define BIT_LIMIT        2
`define BIT_FAULT        1
`define BIT_OUTPUT_ON    0
`define SEL_W            2
`define SEL_CONDITION    2'h0
`define SEL_LATCH        2'h1
`define SEL_MASK         2'h2
`define CAT_W            2
`define CODE_W           16
`define QDEPTH           8
`define QPTR_W           3
`define QCNT_W           4
`define QCNT_ZERO        4'h0
`define QCNT_ONE         4'h1
`define QCNT_FULL        4'h8
`define TOP_ZERO         3'h0
`define QPTR_ZERO        3'h0
`define QPTR_ONE         3'h1

`endif

// ---- change_detector.v ----
`timescale 1ns/1ps
`default_nettype none
`include "status_reporter_defs.vh"

module change_detector
(
  input  wire                mclk,
  input  wire                sys_rst,
  input  wire [`REG_W-1:0]   cond,
  input  wire                clear_pulse,
  output reg  [`REG_W-1:0]   latch_q
);

  reg  [`REG_W-1:0] prev_q;
  wire [`REG_W-1:0] rise_mask = `RISE_MASK;
  wire [`REG_W-1:0] fall_mask = `FALL_MASK;

  genvar i;
  generate
    for (i = 0; i < `REG_W; i = i + 1)
    begin : g_bit
      wire hit;
      // Edge by configured direction
      assign hit = (rise_mask[i] & cond[i] & ~prev_q[i])
                 | (fall_mask[i] & ~cond[i] & prev_q[i]);
      always @(posedge mclk)
      begin
        if (sys_rst)
        begin
          prev_q[i]  <= cond[i];                            // No edge at release
          latch_q[i] <= 1'b0;
        end
        else
        begin
          prev_q[i] <= cond[i];
          if (hit)
            latch_q[i] <= 1'b1;                             // Set wins over clear
          else if (clear_pulse)
            latch_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- status_queue.v ----
`timescale 1ns/1ps
`default_nettype none
`include "status_reporter_defs.vh"

module status_queue
(
  input  wire                 mclk,
  input  wire                 sys_rst,
  input  wire                 flush,
  input  wire                 load_push,
  input  wire [`CODE_W-1:0]   load_code,
  input  wire                 pop,
  output wire [`CODE_W-1:0]   head_code,
  output wire                 nonempty,
  output wire                 full
);

  reg [`CODE_W-1:0] mem [0:`QDEPTH-1];
  reg [`QPTR_W-1:0] rd_q;
  reg [`QPTR_W-1:0] wr_q;
  reg [`QCNT_W-1:0] cnt_q;
  wire do_pop  = pop & (cnt_q != `QCNT_ZERO);
  wire do_push = load_push & ~full;

  assign nonempty  = (cnt_q != `QCNT_ZERO);
  assign full      = (cnt_q == `QCNT_FULL);
  // Empty queue answers code 0
  assign head_code = nonempty ? mem[rd_q] : `REG_ZERO;

  always @(posedge mclk)
  begin
    if (do_push)
      mem[wr_q] <= load_code;
  end

  always @(posedge mclk)
  begin
    if (sys_rst || flush)
    begin
      rd_q  <= `QPTR_ZERO;
      wr_q  <= `QPTR_ZERO;
      cnt_q <= `QCNT_ZERO;
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + `QPTR_ONE;
      if (do_pop)
        rd_q <= rd_q + `QPTR_ONE;
      if (do_push && !do_pop)
        cnt_q <= cnt_q + `QCNT_ONE;
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - `QCNT_ONE;
    end
  end

endmodule

`default_nettype wire

// ---- instrument_status_change_reporter.v ----
// Contract
// - Bit 11 shows remote control state
// - Bit 10 shows sweep in progress
// - Bit 9 mirrors cal compensation switch
// - Bit 8 shows external reference selected
// - Bits 7/6 show AM over/under
// - Bits 5/4 show FM over/under
// - Bits 3/2 show reverse trip, limited region
// - Bits 1/0 show fault, output on
// - Change bits set on configured edge
// - Enabled set change bit raises summary flag
// - All-zero mask never raises summary flag
// - Mask kept across power cycles
// - Queries return whole 16-bit value
// - Reading change latch clears it
// - Change latch zero at power-up
// - Mask written only by remote command
// - Status load flushes, then loads category
// - Status query pops oldest, empty gives 0
// - Queue-nonempty flag reflects queue state
// - Queue emptied at power-up and clear-status
`timescale 1ns/1ps
`default_nettype none
`include "status_reporter_defs.vh"

module instrument_status_change_reporter
(
  input  wire                 mclk,
  input  wire                 sys_rst,
  input  wire                 remote_active,
  input  wire                 sweep_active,
  input  wire                 cal_compensation_switch,
  input  wire                 external_reference_selected,
  input  wire                 amplitude_mod_over,
  input  wire                 amplitude_mod_under,
  input  wire                 frequency_mod_over,
  input  wire                 frequency_mod_under,
  input  wire                 reverse_power_trip,
  input  wire                 limited_region,
  input  wire                 hardware_fault,
  input  wire                 output_enabled_flag,
  input  wire                 condition_valid,
  input  wire                 query_strobe,
  input  wire [`SEL_W-1:0]    query_select,
  input  wire                 mask_write_strobe,
  input  wire [`REG_W-1:0]    mask_write_value,
  input  wire [`REG_W-1:0]    mask_restore_value,
  input  wire                 status_load_strobe,
  input  wire [`CAT_W-1:0]    status_category,
  input  wire                 status_entry_valid,
  input  wire [`CODE_W-1:0]   status_entry_code,
  input  wire                 status_query_strobe,
  input  wire                 clear_status,
  output reg  [`REG_W-1:0]    query_response,
  output reg                  query_response_valid,
  output reg  [`CODE_W-1:0]   status_response,
  output reg                  status_response_valid,
  output reg                  change_summary_flag,
  output reg                  status_queue_nonempty,
  output reg  [`CAT_W-1:0]    loaded_category,
  output reg                  status_queue_full,
  output reg  [`REG_W-1:0]    mask_store_value
);

  reg  [`REG_W-1:0]  cond_q;
  reg  [`REG_W-1:0]  mask_q;
  wire [`REG_W-1:0]  latch_w;
  wire [`REG_W-1:0]  cond_d;
  wire [`CODE_W-1:0] head_w;
  wire               nonempty_w;
  wire               full_w;
  wire               latch_read;

  // Live condition bits
  assign cond_d[`REG_W-1:`BIT_VALID+1] = `TOP_ZERO;
  assign cond_d[`BIT_VALID]     = condition_valid;
  assign cond_d[`BIT_REMOTE]    = remote_active;
  assign cond_d[`BIT_SWEEP]     = sweep_active;
  assign cond_d[`BIT_CAL_COMPENSATION_SWITCH]   = cal_compensation_switch;
  assign cond_d[`BIT_EXTERNAL_REFERENCE_SELECTED]    = external_reference_selected;
  assign cond_d[`BIT_AM_OVER]   = amplitude_mod_over;
  assign cond_d[`BIT_AM_UNDER]  = amplitude_mod_under;
  assign cond_d[`BIT_FM_OVER]   = frequency_mod_over;
  assign cond_d[`BIT_FM_UNDER]  = frequency_mod_under;
  assign cond_d[`BIT_REV_POWER] = reverse_power_trip;
  assign cond_d[`BIT_LIMIT]     = limited_region;
  assign cond_d[`BIT_FAULT]     = hardware_fault;
  assign cond_d[`BIT_OUTPUT_ON] = output_enabled_flag;

  assign latch_read = query_strobe && (query_select == `SEL_LATCH);

  // Tracks inputs through reset, no false edge at release
  always @(posedge mclk)
  begin
    cond_q <= cond_d;
  end

  change_detector u_change
  (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .cond        (cond_q),
    .clear_pulse (latch_read),
    .latch_q     (latch_w)
  );

  // Mask restored from storage, writable only remotely
  always @(posedge mclk)
  begin
    if (sys_rst)
      mask_q <= mask_restore_value & `USED_BITS_MASK;
    else if (mask_write_strobe)
      mask_q <= mask_write_value & `USED_BITS_MASK;
  end

  status_queue u_queue
  (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .flush     (status_load_strobe | clear_status),
    .load_push (status_entry_valid & ~status_load_strobe & ~clear_status),
    .load_code (status_entry_code),
    .pop       (status_query_strobe),
    .head_code (head_w),
    .nonempty  (nonempty_w),
    .full      (full_w)
  );

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      query_response        <= `REG_ZERO;
      query_response_valid  <= 1'b0;
      status_response       <= `REG_ZERO;
      status_response_valid <= 1'b0;
      change_summary_flag   <= 1'b0;
      status_queue_nonempty <= 1'b0;
      loaded_category       <= {`CAT_W{1'b0}};
      status_queue_full     <= 1'b0;
      mask_store_value      <= `REG_ZERO;
    end
    else
    begin
      query_response_valid <= query_strobe;
      if (query_strobe)
      begin
        case (query_select)
          `SEL_CONDITION: query_response <= cond_q;
          `SEL_LATCH:     query_response <= latch_w;
          `SEL_MASK:      query_response <= mask_q;
          default:        query_response <= `REG_ZERO;
        endcase
      end
      status_response_valid <= status_query_strobe;
      if (status_query_strobe)
        status_response <= head_w;
      // Summary from enabled latched changes
      change_summary_flag   <= |(latch_w & mask_q);
      status_queue_nonempty <= nonempty_w;
      status_queue_full     <= full_w;
      if (status_load_strobe)
        loaded_category <= status_category;
      mask_store_value <= mask_q;
    end
  end

endmodule

`default_nettype wire

// ---- status_change_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module status_change_monitor
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        query_strobe,
  input wire logic [1:0]  query_select,
  input wire logic        status_load_strobe,
  input wire logic        status_query_strobe,
  input wire logic        clear_status,
  input wire logic [15:0] query_response,
  input wire logic        query_response_valid,
  input wire logic        status_response_valid,
  input wire logic        change_summary_flag,
  input wire logic        status_queue_nonempty,
  input wire logic [15:0] mask_store_value
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  sequence latch_read;
    query_strobe && query_select == 2'h1;
  endsequence
  query_answer_a:
    assert property (query_strobe |=> query_response_valid)
    else $error("query not answered");
  lone_answer_a:
    assert property (!query_strobe |=> !query_response_valid)
    else $error("answer without query");
  top_bits_a:
    assert property (query_response_valid |-> query_response[15:13] == 3'h0)
    else $error("upper bits set");
  status_answer_a:
    assert property (status_query_strobe |=> status_response_valid)
    else $error("status not answered");
  read_clears_a:
    assert property (latch_read ##2 latch_read |=> query_response == 16'h0000)
    else $error("latch not cleared");
  mask_off_a:
    assert property ((mask_store_value == 16'h0000) [*3] |-> !change_summary_flag)
    else $error("summary with mask clear");
  load_flush_a:
    assert property (status_load_strobe |-> ##2 !status_queue_nonempty)
    else $error("queue kept over load");
  clear_empty_a:
    assert property (clear_status |-> ##2 !status_queue_nonempty)
    else $error("queue kept over clear");
  reset_state_a:
    assert property ($fell(sys_rst) |-> !change_summary_flag && !status_queue_nonempty)
    else $error("state left after reset");
endmodule
bind instrument_status_change_reporter status_change_monitor mon
(
  .mclk, .sys_rst, .query_strobe, .query_select, .status_load_strobe, .status_query_strobe,
  .clear_status, .query_response, .query_response_valid, .status_response_valid,
  .change_summary_flag, .status_queue_nonempty, .mask_store_value
);
`default_nettype wire

// ---- bus_controller_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_controller_model
(
  input  wire logic        mclk,
  output var  logic        query_strobe,
  output var  logic [1:0]  query_select,
  output var  logic        mask_write_strobe,
  output var  logic [15:0] mask_write_value,
  output var  logic        status_load_strobe,
  output var  logic [1:0]  status_category,
  output var  logic        status_entry_valid,
  output var  logic [15:0] status_entry_code,
  output var  logic        status_query_strobe,
  output var  logic        clear_status
);
  initial
  begin
    {query_strobe, query_select, mask_write_strobe, mask_write_value} = 20'h0_0000;
    {status_load_strobe, status_category, status_entry_valid} = 4'h0;
    {status_entry_code, status_query_strobe, clear_status} = 18'h0_0000;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  // Released select, mask and code lines show the inverse of the last value; status_category keeps its value
  task automatic reg_query(input logic [1:0] sel);
    query_select = sel;
    query_strobe = 1'b1;
    step();
    query_strobe = 1'b0;
    query_select = ~sel;
    step();
  endtask
  task automatic mask_write(input logic [15:0] val);
    mask_write_value = val;
    mask_write_strobe = 1'b1;
    step();
    mask_write_strobe = 1'b0;
    mask_write_value = ~val;
    step();
  endtask
  task automatic status_load(input logic [1:0] cat, input int n, input logic [15:0] base);
    status_category = cat;
    status_load_strobe = 1'b1;
    step();
    status_load_strobe = 1'b0;
    step();
    for (int i = 0; i < n; i++)
    begin
      status_entry_code = base + 16'(i);
      status_entry_valid = 1'b1;
      step();
      status_entry_valid = 1'b0;
      status_entry_code = ~status_entry_code;
      step();
    end
  endtask
  task automatic status_pop();
    status_query_strobe = 1'b1;
    step();
    status_query_strobe = 1'b0;
    step();
  endtask
  task automatic clear_queue();
    clear_status = 1'b1;
    step();
    clear_status = 1'b0;
    step();
  endtask
endmodule
`default_nettype wire

// ---- instrument_status_change_reporter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module instrument_status_change_reporter_tb;
  logic        mclk, sys_rst, query_strobe, mask_write_strobe, status_load_strobe;
  logic        status_entry_valid, status_query_strobe, clear_status, query_response_valid;
  logic        status_response_valid, change_summary_flag, status_queue_nonempty;
  logic        status_queue_full;
  logic [1:0]  query_select, status_category, loaded_category;
  logic [12:0] cond;
  logic [15:0] mask_restore_value, mask_write_value, status_entry_code, query_response;
  logic [15:0] status_response, mask_store_value;
  int          err_total, checks;
  bus_controller_model ctl
  (
    .mclk, .query_strobe, .query_select, .mask_write_strobe, .mask_write_value,
    .status_load_strobe, .status_category, .status_entry_valid, .status_entry_code,
    .status_query_strobe, .clear_status
  );
  instrument_status_change_reporter DUT
  (
    .mclk, .sys_rst, .remote_active(cond[11]), .sweep_active(cond[10]),
    .cal_compensation_switch(cond[9]), .external_reference_selected(cond[8]),
    .amplitude_mod_over(cond[7]), .amplitude_mod_under(cond[6]),
    .frequency_mod_over(cond[5]), .frequency_mod_under(cond[4]),
    .reverse_power_trip(cond[3]), .limited_region(cond[2]), .hardware_fault(cond[1]),
    .output_enabled_flag(cond[0]), .condition_valid(cond[12]), .query_strobe,
    .query_select, .mask_write_strobe, .mask_write_value, .mask_restore_value,
    .status_load_strobe, .status_category, .status_entry_valid, .status_entry_code,
    .status_query_strobe, .clear_status, .query_response, .query_response_valid,
    .status_response, .status_response_valid, .change_summary_flag,
    .status_queue_nonempty, .loaded_category, .status_queue_full, .mask_store_value
  );
  initial
    mclk = 1'b0;
  always #10 mclk = ~mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rq(input logic [1:0] sel, input logic [15:0] exp);
    ctl.reg_query(sel);
    chk(query_response, exp);
  endtask
  task automatic sq(input logic [15:0] exp);
    ctl.status_pop();
    chk(status_response, exp);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    close_out();
  end
  initial
  begin
    sys_rst = 1'b1;
    cond = 13'h0000;
    mask_restore_value = 16'h0108;
    repeat (3) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    rq(2'h2, 16'h0108);
    chk(mask_store_value, 16'h0108);
    rq(2'h1, 16'h0000);
    sq(16'h0000);
    chk({15'h0000, status_queue_nonempty}, 16'h0000);
    $display("reset test end");
    // Each bit alone: level, then rising and falling latch
    for (int i = 0; i < 13; i++)
    begin
      cond = 13'h0001 << i;
      repeat (3) ctl.step();
      rq(2'h0, 16'h0001 << i);
      rq(2'h1, 16'h1bff & (16'h0001 << i));
      cond = 13'h0000;
      repeat (3) ctl.step();
      rq(2'h1, 16'h0f01 & (16'h0001 << i));
      rq(2'h1, 16'h0000);
    end
    $display("condition test end");
    ctl.mask_write(16'h0000);
    cond = 13'h0008;
    repeat (4) ctl.step();
    chk({15'h0000, change_summary_flag}, 16'h0000);
    ctl.mask_write(16'h0008);
    chk({15'h0000, change_summary_flag}, 16'h0001);
    rq(2'h1, 16'h0008);
    chk({15'h0000, change_summary_flag}, 16'h0000);
    cond = 13'h0000;
    repeat (4) ctl.step();
    chk({15'h0000, change_summary_flag}, 16'h0000);
    ctl.mask_write(16'hffff);
    rq(2'h2, 16'h1fff);
    rq(2'h3, 16'h0000);
    $display("mask test end");
    for (int c = 0; c < 4; c++)
    begin
      ctl.status_load(2'(c), 2, 16'(c * 16 + 1));
      chk({14'h0000, loaded_category}, 16'(c));
      chk({15'h0000, status_queue_nonempty}, 16'h0001);
    end
    sq(16'h0031);
    sq(16'h0032);
    sq(16'h0000);
    chk({15'h0000, status_queue_nonempty}, 16'h0000);
    ctl.status_load(2'h1, 9, 16'h0100);
    chk({15'h0000, status_queue_full}, 16'h0001);
    sq(16'h0100);
    ctl.clear_queue();
    chk({15'h0000, status_queue_nonempty}, 16'h0000);
    sq(16'h0000);
    $display("queue test end");
    ctl.mask_write(16'h0048);
    cond = 13'h0001;
    ctl.status_load(2'h2, 1, 16'h0007);
    mask_restore_value = mask_store_value;
    sys_rst = 1'b1;
    repeat (3) ctl.step();
    sys_rst = 1'b0;
    rq(2'h2, 16'h0048);
    rq(2'h1, 16'h0000);
    chk({15'h0000, status_queue_nonempty}, 16'h0000);
    rq(2'h0, 16'h0001);
    $display("restart test end");
    close_out();
  end
endmodule
`default_nettype wire
